// file: common/wcs_pkg.sv
// Package of constants and types for the windowed countdown supervisor.
package wcs_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses on APB).
   // ------------------------------------------------------------------
   localparam logic [11:0] WCS_OFF_CTRL = 12'h000;
   localparam logic [11:0] WCS_OFF_STAT = 12'h004;
   localparam logic [11:0] WCS_OFF_MASK = 12'h008;
   localparam logic [11:0] WCS_OFF_MODE = 12'h00c;

   // ------------------------------------------------------------------
   // Field layout and reset values.
   // ------------------------------------------------------------------
   localparam int WCS_ARM_POS = 7;
   localparam int WCS_TOP_POS = 6;
   localparam logic [7:0] WCS_CTRL_RST = 8'h7f;
   localparam int WCS_ST_SUPRST = 0;
   localparam int WCS_ST_SWRST = 1;
   localparam int WCS_ST_W = 2;
   localparam int WCS_MODE_HALT = 0;
   localparam int WCS_MODE_WAKE = 1;
   localparam int WCS_MODE_HWOPT = 2;

   // ------------------------------------------------------------------
   // Timing.
   // ------------------------------------------------------------------
   localparam int WCS_STEP_CYC = 65536;
   localparam int WCS_WAKE_CYC = 514;
   localparam int WCS_CLK_MHZ = 250;
   localparam int WCS_PULSE_NS = 500;
   // A least time: round up to whole cycles.
   localparam int WCS_PULSE_CYC =
      (WCS_PULSE_NS * WCS_CLK_MHZ + 999) / 1000;

   // Supervisor status carried from the core to the register file.
   typedef struct packed {
      logic [7:0] ctrl;
      logic rst_ev;
      logic swrst_ev;
      logic rst_active;
   } wcs_stat_t;

endpackage : wcs_pkg

// file: design/wcs_cycle_counter.sv
// Parameterised cycle counter that pulses once every PERIOD enabled cycles.
module wcs_cycle_counter #(
   parameter int PERIOD = 65536
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_run,
   input wire logic i_clear,
   output logic o_tick
);
   localparam int W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire at_last = (cnt_q == LAST);

   // Counter wraps at the period; clear restarts the interval.
   assign cnt_d = i_clear ? '0 : (!i_run ? cnt_q :
                  (at_last ? '0 : cnt_q + W'(1)));

   // ------------------------------------------------------------------
   // State.
   // ------------------------------------------------------------------
   // The tick is registered so the consumer sees a clean one-cycle pulse.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         o_tick <= i_run && at_last && !i_clear;
      end
   end
endmodule : wcs_cycle_counter

// file: design/wcs_apb_regs.sv
// APB slave holding status, mask and mode registers of the supervisor.
module wcs_apb_regs
   import wcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire wcs_pkg::wcs_stat_t i_stat,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_ctrl_wr,
   output logic [7:0] o_ctrl_wdata,
   output logic [2:0] o_mode,
   output logic o_irq
);
   import wcs_pkg::*;

   logic [WCS_ST_W-1:0] stat_q;
   logic [WCS_ST_W-1:0] stat_d;
   logic [WCS_ST_W-1:0] mask_q;
   logic [2:0] mode_q;

   // ------------------------------------------------------------------
   // Decode.
   // ------------------------------------------------------------------
   // Access phase completes in two cycles; pready is registered so it
   // rises the cycle after penable goes high.
   wire acc = i_psel && i_penable && !o_pready;
   wire wr = acc && i_pwrite && i_pstrb[0];
   wire hit_ctrl = (i_paddr == WCS_OFF_CTRL);
   wire hit_stat = (i_paddr == WCS_OFF_STAT);
   wire hit_mask = (i_paddr == WCS_OFF_MASK);
   wire hit_mode = (i_paddr == WCS_OFF_MODE);
   wire hit_any = hit_ctrl || hit_stat || hit_mask || hit_mode;
   wire [WCS_ST_W-1:0] ev = {i_stat.swrst_ev, i_stat.rst_ev};
   wire [WCS_ST_W-1:0] w1c = (wr && hit_stat) ?
                             i_pwdata[WCS_ST_W-1:0] : '0;
   wire [31:0] rdata =
      hit_ctrl ? {24'h000000, i_stat.ctrl} :
      hit_stat ? {30'h00000000, stat_q} :
      hit_mask ? {30'h00000000, mask_q} :
      hit_mode ? {29'h00000000, mode_q} : 32'h00000000;

   // Event set wins over the write-one clear in the same cycle.
   assign stat_d = (stat_q & ~w1c) | ev; // RULE13

   // ------------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------------
   // Status survives supervisor resets so software can read the cause.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stat_q <= '0;
         mask_q <= '0;
         mode_q <= '0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
         o_ctrl_wr <= 1'b0;
         o_ctrl_wdata <= 8'h00;
         o_irq <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr && hit_mask) mask_q <= i_pwdata[WCS_ST_W-1:0];
         if (wr && hit_mode) mode_q <= i_pwdata[2:0];
         o_pready <= acc;
         o_pslverr <= acc && !hit_any;
         o_prdata <= acc ? rdata : 32'h00000000;
         o_ctrl_wr <= wr && hit_ctrl;
         o_ctrl_wdata <= i_pwdata[7:0];
         o_irq <= |(stat_d & mask_q);
      end
   end

   assign o_mode = mode_q;
endmodule : wcs_apb_regs

// file: design/wcs_supervisor.sv
// Top of the windowed countdown supervisor timer.
// Functional notes
// RULE1: Countdown drops by one every 65,536 clock cycles.
// RULE2: When armed, top bit clearing launches a reset pulse of about 500 ns.
// RULE3: Countdown keeps running while disarmed; only the reset is suppressed.
// RULE4: Software rewrites control with FFh..C0h periodically.
// RULE5: Refresh sets arm and top bit; low six bits give steps before reset.
// RULE6: FFh gives 524.288 ms and C0h gives 8.192 ms at 8 MHz.
// RULE7: Software option: disarmed after every reset, stays armed once armed.
// RULE8: Writing arm set with top bit clear forces an immediate reset.
// RULE9: Hardware option keeps the supervisor armed, ignoring the arm bit.
// RULE10: Wait mode has no effect; counting and reset act as in run.
// RULE11: In halt the countdown freezes and no reset is produced.
// RULE12: After halt wake-up counting resumes only after 514 clocks.
// RULE13: A status flag records that the supervisor caused the last reset.
// RULE14: Software refreshes the countdown just before entering halt.
// RULE15: Control holds arm at bit 7 and the count in bits 6..0.
// RULE16: Software can set the arm bit but never clear it.
// RULE17: Control resets to 7Fh: disarmed, count at maximum.
// RULE18: A control write loads the count at once and may set arm.
// RULE19: Reset pulse length comes from a small cycle counter.
//
// The register addresses and the APB interface to the registers were decided locally.
module wcs_supervisor
   import wcs_pkg::*;
#(
   parameter int STEP_CYC = WCS_STEP_CYC,
   parameter int WAKE_CYC = WCS_WAKE_CYC,
   parameter int PULSE_CYC = WCS_PULSE_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq,
   output logic o_rst_n
);
   import wcs_pkg::*;

   typedef enum logic [1:0] {
      WCS_RUN = 2'b00,
      WCS_HALT = 2'b01,
      WCS_WAKE = 2'b10
   } wcs_state_t;

   localparam int PW = $clog2(PULSE_CYC + 1);

   // ------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   wcs_state_t state_q;
   wcs_state_t state_d;
   logic [PW-1:0] pulse_q;
   logic [PW-1:0] pulse_d;
   logic rst_n_q;
   logic rst_ev_q;
   logic swrst_ev_q;
   logic hw_opt_q;
   logic step_tick;
   logic wake_tick;
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic [2:0] mode;
   wcs_stat_t stat;
   // Declared here because the step prescaler's run input reads it.
   logic pulse_active;

   // ------------------------------------------------------------------
   // Register file.
   // ------------------------------------------------------------------
   assign stat.ctrl = ctrl_q;
   assign stat.rst_ev = rst_ev_q;
   assign stat.swrst_ev = swrst_ev_q;
   assign stat.rst_active = !rst_n_q;

   wcs_apb_regs u_regs (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .i_pstrb(i_pstrb),
      .i_stat(stat),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .o_ctrl_wr(ctrl_wr),
      .o_ctrl_wdata(ctrl_wdata),
      .o_mode(mode),
      .o_irq(o_irq)
   );

   // ------------------------------------------------------------------
   // Power-mode sequencing.
   // ------------------------------------------------------------------
   wire halt_req = mode[WCS_MODE_HALT];
   wire wake_req = mode[WCS_MODE_WAKE];
   wire running = (state_q == WCS_RUN); // RULE10
   wire in_wake = (state_q == WCS_WAKE);

   // Halt freezes; wake-up passes through a fixed restart delay.
   always_comb begin
      state_d = state_q;
      case (state_q)
         WCS_RUN: begin
            if (halt_req) state_d = WCS_HALT; // RULE11
         end
         WCS_HALT: begin
            if (wake_req) state_d = WCS_WAKE;
         end
         WCS_WAKE: begin
            if (wake_tick) state_d = WCS_RUN; // RULE12
         end
         default: begin
            state_d = WCS_RUN;
         end
      endcase
   end

   // Step prescaler only advances in run; halt holds its phase.
   wcs_cycle_counter #(.PERIOD(STEP_CYC)) u_step (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(running && !pulse_active),
      .i_clear(1'b0),
      .o_tick(step_tick) // RULE1
   );

   // Restart delay counter, cleared whenever not waking.
   wcs_cycle_counter #(.PERIOD(WAKE_CYC)) u_wake (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(in_wake && !wake_tick),
      .i_clear(!in_wake),
      .o_tick(wake_tick) // RULE12
   );

   // ------------------------------------------------------------------
   // Countdown and arming.
   // ------------------------------------------------------------------
   assign pulse_active = (pulse_q != '0);
   wire armed = ctrl_q[WCS_ARM_POS] || hw_opt_q; // RULE9
   wire [6:0] cnt_dec = ctrl_q[6:0] - 7'h01; // RULE6
   wire dec_now = step_tick && running && !ctrl_wr;
   // Top bit falls on the 40h to 3Fh step.
   wire roll = dec_now && (ctrl_q[6:0] == 7'h40); // RULE2
   wire sw_rst = ctrl_wr && ctrl_wdata[WCS_ARM_POS] &&
                 !ctrl_wdata[WCS_TOP_POS]; // RULE8
   wire fire = !pulse_active && ((roll && armed) || sw_rst); // RULE2

   // A write replaces the count and may only set arm; a decrement
   // keeps counting whether armed or not.
   assign ctrl_d =
      pulse_active ? WCS_CTRL_RST :               // RULE17
      ctrl_wr ? {ctrl_q[WCS_ARM_POS] | ctrl_wdata[WCS_ARM_POS],
                 ctrl_wdata[6:0]} :                // RULE18 RULE16
      dec_now ? {ctrl_q[WCS_ARM_POS], cnt_dec} :   // RULE3
      ctrl_q;

   // Pulse counter loads on a fire and counts down to zero.
   assign pulse_d = fire ? PW'(PULSE_CYC) :
                    (pulse_active ? pulse_q - PW'(1) : pulse_q); // RULE19

   // ------------------------------------------------------------------
   // State.
   // ------------------------------------------------------------------
   // The supervisor reset returns the control register and power state
   // to their reset values, so the software option comes back disarmed.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_q <= WCS_CTRL_RST; // RULE17 RULE7
         state_q <= WCS_RUN;
         pulse_q <= '0;
         rst_n_q <= 1'b1;
         rst_ev_q <= 1'b0;
         swrst_ev_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d; // RULE15
         state_q <= pulse_active ? WCS_RUN : state_d;
         pulse_q <= pulse_d;
         rst_n_q <= !(fire || (pulse_active && pulse_q != PW'(1)));
         rst_ev_q <= fire; // RULE13
         swrst_ev_q <= fire && sw_rst;
      end
   end

   // Option strap copied from the mode register; it cannot be changed by
   // the supervisor's own reset, mimicking a non-volatile option byte.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         hw_opt_q <= 1'b0;
      end else begin
         hw_opt_q <= mode[WCS_MODE_HWOPT]; // RULE9
      end
   end

   assign o_rst_n = rst_n_q;
endmodule : wcs_supervisor

// file: verification/wcs_supervisor_checker.sv
// Port-level assertions for the countdown supervisor, bound to its top.
module wcs_supervisor_checker #(
   parameter int PULSE_CYC = 4
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_irq,
   input wire logic o_rst_n
);
   // ---------------------------------------------------------------
   // Helper logic.
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   logic access;
   // Only the four aligned words are decoded; any other offset errs.
   wire mapped = (i_paddr == 12'h000) || (i_paddr == 12'h004) ||
                 (i_paddr == 12'h008) || (i_paddr == 12'h00c);
   logic [7:0] low_cnt_q;
   logic [7:0] low_cnt_d;
   // Low cycles of the current pulse; an endless pulse trips the bound.
   assign access = i_psel && i_penable && !o_pready;
   assign low_cnt_d = o_rst_n ? 8'h00 : low_cnt_q + 8'h01;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         low_cnt_q <= 8'h00;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end
   // ---------------------------------------------------------------
   // Assertions and covers.
   // ---------------------------------------------------------------
   a_pready_answer: assert property (access |=> o_pready)
      else $error("pready missing after access");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (access && !mapped |=> o_pslverr)
      else $error("unmapped access without error");
   a_err_mapped: assert property (access && mapped |=> !o_pslverr)
      else $error("mapped access with error");
   a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   a_pulse_len: assert property ($rose(o_rst_n) |-> low_cnt_q == 8'(PULSE_CYC))
      else $error("reset pulse length wrong");
   a_pulse_bound: assert property (!o_rst_n |-> low_cnt_q < 8'(PULSE_CYC))
      else $error("reset pulse too long");
   a_reset_quiet: assert property ($fell(i_sys_rst) |-> o_rst_n && !o_irq)
      else $error("outputs busy after reset");
   c_pulse: cover property ($fell(o_rst_n));
   c_slverr: cover property (o_pready && o_pslverr);
   c_irq: cover property ($rose(o_irq));
endmodule : wcs_supervisor_checker

bind wcs_supervisor wcs_supervisor_checker #(
   .PULSE_CYC(PULSE_CYC)
) wcs_supervisor_checker_inst (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
   .o_rst_n(o_rst_n)
);

// file: verification/testbench.sv
// Self-checking testbench for the countdown supervisor.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wcs_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus signals and the design.
   // ---------------------------------------------------------------
   localparam int STEP = 16;
   localparam int WAKE = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rdat, v;
   logic pready, pslverr, irq, rst_n, rerr;
   int n_errors = 0;
   int checks_done = 0;
   int n_pulse = 0;
   wcs_supervisor #(.STEP_CYC(STEP), .WAKE_CYC(WAKE), .PULSE_CYC(4))
   wcs_supervisor_inst (
      .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_irq(irq), .o_rst_n(rst_n)
   );
   // Clock and a count of reset pulses seen at the output.
   always #2 clk = ~clk;
   always @(negedge rst_n) n_pulse++;
   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic finish_test;
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // One APB transfer; the trailing edge keeps strobes from doubling up.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_count;
      apb(0, WCS_OFF_CTRL, 0);
      chk(rdat, 32'h7f);
      apb(0, 12'h010, 0);
      chk({31'h0, rerr}, 32'h1);
      apb(1, WCS_OFF_MASK, 32'h1);
      apb(1, WCS_OFF_CTRL, 32'h50);
      apb(0, WCS_OFF_CTRL, 0);
      v = rdat;
      // Exactly 64 edges lie between the two samples: four steps.
      cyc(60);
      apb(0, WCS_OFF_CTRL, 0);
      chk(v - rdat, 32'h4);
      // Disarmed: the count passes the threshold without a pulse.
      apb(1, WCS_OFF_CTRL, 32'h41);
      cyc(60);
      apb(0, WCS_OFF_CTRL, 0);
      chk(rdat & 32'hc0, 32'h0);
      chk(n_pulse, 0);
   endtask : t_count
   task automatic t_hwopt;
      apb(1, WCS_OFF_MODE, 32'h4);
      apb(1, WCS_OFF_CTRL, 32'h41);
      cyc(60);
      chk(n_pulse, 1);
      apb(1, WCS_OFF_MODE, 32'h0);
      apb(0, WCS_OFF_STAT, 0);
      chk(rdat, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1, WCS_OFF_STAT, 32'h1);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
   endtask : t_hwopt
   task automatic t_swrst;
      apb(1, WCS_OFF_CTRL, 32'h80);
      cyc(20);
      chk(n_pulse, 2);
      apb(0, WCS_OFF_STAT, 0);
      chk(rdat, 32'h3);
      apb(1, WCS_OFF_STAT, 32'h3);
   endtask : t_swrst
   task automatic t_arm;
      apb(1, WCS_OFF_CTRL, 32'hc1);
      cyc(10);
      chk(n_pulse, 2);
      cyc(50);
      chk(n_pulse, 3);
      apb(1, WCS_OFF_STAT, 32'h1);
      apb(1, WCS_OFF_CTRL, 32'h41);
      cyc(60);
      chk(n_pulse, 3);
   endtask : t_arm
   task automatic t_halt;
      apb(1, WCS_OFF_CTRL, 32'hff);
      apb(1, WCS_OFF_CTRL, 32'h7f);
      apb(0, WCS_OFF_CTRL, 0);
      chk(rdat & 32'h80, 32'h80);
      apb(1, WCS_OFF_MODE, 32'h1);
      apb(0, WCS_OFF_CTRL, 0);
      v = rdat;
      cyc(100);
      apb(0, WCS_OFF_CTRL, 0);
      chk(rdat, v);
      apb(1, WCS_OFF_MODE, 32'h2);
      cyc(WAKE + 3 * STEP);
      apb(0, WCS_OFF_CTRL, 0);
      chk({31'h0, rdat < v}, 32'h1);
      chk(n_pulse, 3);
   endtask : t_halt
   // Main sequence: reset, then the scenarios in turn.
   initial begin
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      t_count();
      t_hwopt();
      t_swrst();
      t_arm();
      t_halt();
      finish_test();
   end
   // Watchdog against a hung handshake.
   initial begin
      #20000;
      n_errors++;
      finish_test();
   end
endmodule : testbench
